// ---- logic/ssa_top.sv ----
// AHB-Lite register front end, accumulator, flags and data memory
// of the subtract/swap slice.
// Assumes a single master; hready is this slave's own hreadyout.
//
// The implementer's own choices: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ns

module ssa_top #(
	parameter int MEM_DEPTH = 16
) (
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata
);
	localparam int MIW = (MEM_DEPTH > 1) ? $clog2(MEM_DEPTH) : 1;

	typedef struct packed {
		logic                        ready;
		logic                        resp;
		logic [31:0]                 rdata;
		logic                        pend_wr;
		logic                        pend_rd;
		logic [7:0]                  addr;
		logic [7:0]                  accumulator_reg;
		logic [3:0]                  flags;
		logic [31:0]                 cmd;
		logic [MEM_DEPTH-1:0][7:0]   mem;
	} ssa_state_t;

	ssa_state_t  s_q;
	ssa_state_t  s_d;

	ssa_alu_if   alu_bus ();

	logic [7:0]     mem_off;
	logic [5:0]     word_idx;
	logic           in_mem;
	logic [MIW-1:0] mem_idx;
	logic [MIW-1:0] cmd_idx;
	logic [7:0]     cmd_imm;
	logic           cmd_go;
	logic           accept;
	logic           nonseq;
	logic [1:0]     cmd_op;
	logic           mem_aligned;
	logic           sel_acc;
	logic           sel_flags;
	logic           sel_cmd;
	logic           sel_mem;
	logic           wr_acc_bus;
	logic           wr_flags_bus;
	logic           wr_cmd_bus;
	logic           wr_mem_bus;
	logic           cmd_in_range;
	logic           res_to_acc;
	logic           res_to_mem;
	logic           res_to_flags;
	logic [7:0]     operand_mem;
	logic [7:0]     wr_byte;
	logic [3:0]     wr_nibble;
	logic [31:0]    rd_acc_word;
	logic [31:0]    rd_flags_word;
	logic [31:0]    rd_mem_word;

	ssa_alu i_ssa_alu (
		.u (alu_bus.alu)
	);

	// Decode of the latched data-phase address
	assign mem_off  = s_q.addr - ssa_pkg::OFF_MEM;
	assign word_idx = mem_off[7:2];
	// An unaligned offset inside the memory window would alias a byte
	assign mem_aligned = (mem_off[1:0] == 2'h0);
	assign in_mem   = (s_q.addr >= ssa_pkg::OFF_MEM)
		&& (32'(word_idx) < MEM_DEPTH) && mem_aligned;
	assign mem_idx  = word_idx[MIW-1:0];

	// One select per register; at most one is high for any offset
	assign sel_acc   = (s_q.addr == ssa_pkg::OFF_ACC);
	assign sel_flags = (s_q.addr == ssa_pkg::OFF_FLAGS);
	assign sel_cmd   = (s_q.addr == ssa_pkg::OFF_CMD);
	assign sel_mem   = in_mem;

	// Bus write strobes, live in a write data phase only
	assign wr_acc_bus   = s_q.pend_wr && sel_acc;
	assign wr_flags_bus = s_q.pend_wr && sel_flags;
	assign wr_cmd_bus   = s_q.pend_wr && sel_cmd;
	assign wr_mem_bus   = s_q.pend_wr && sel_mem;

	// Accumulator and memory keep the low byte of a written word, flags the low nibble; the command register keeps the whole word
	assign wr_byte   = hwdata[7:0];
	assign wr_nibble = hwdata[3:0];

	// Read words, zero above the stored bits
	assign rd_acc_word   = {24'h000000, s_q.accumulator_reg};
	assign rd_flags_word = {28'h0000000, s_q.flags};
	assign rd_mem_word   = {24'h000000, s_q.mem[mem_idx]};

	// Command fields come straight from the write data
	assign cmd_idx  = hwdata[ssa_pkg::CMD_ADDR_LSB +: MIW];
	assign cmd_imm  = hwdata[ssa_pkg::CMD_IMM_LSB +: 8];
	assign cmd_op   = hwdata[ssa_pkg::CMD_OP_LSB +: 2];
	assign cmd_go   = wr_cmd_bus;

	// An index past the last byte reads as zero and stores nothing,
	// so a depth that is not a power of two cannot alias a byte
	assign cmd_in_range = (32'(cmd_idx) < MEM_DEPTH);
	assign operand_mem  = cmd_in_range ? s_q.mem[cmd_idx] : 8'h00;

	assign nonseq   = (htrans == ssa_pkg::HTRANS_NONSEQ);
	assign accept   = hsel && hready && nonseq;

	assign alu_bus.op = ssa_pkg::ssa_op_t'(cmd_op);
	assign alu_bus.accumulator_reg = s_q.accumulator_reg;

	assign alu_bus.operand = (alu_bus.op == ssa_pkg::OP_SUB_IMM)
		? cmd_imm : operand_mem;

	// Results land only in the data phase of a command write
	assign res_to_acc   = cmd_go && alu_bus.wr_acc;
	assign res_to_mem   = cmd_go && alu_bus.wr_mem && cmd_in_range;
	assign res_to_flags = cmd_go && alu_bus.wr_flags;

	always_comb begin
		s_d      = s_q;
		s_d.resp = ssa_pkg::HRESP_OKAY;

		// Write data phase; unmapped offsets are ignored
		if (s_q.pend_wr) begin
			s_d.pend_wr = 1'b0;
		end
		if (wr_acc_bus) begin
			s_d.accumulator_reg = wr_byte;
		end
		if (wr_flags_bus) begin
			s_d.flags = wr_nibble;
		end
		if (wr_cmd_bus) begin
			s_d.cmd = hwdata;
		end
		if (wr_mem_bus) begin
			s_d.mem[mem_idx] = wr_byte;
		end

		if (res_to_acc) begin
			s_d.accumulator_reg = alu_bus.result;
		end
		if (res_to_mem) begin
			s_d.mem[cmd_idx] = alu_bus.result;
		end
		if (res_to_flags) begin
			s_d.flags = alu_bus.flags;
		end

		// Read data phase: one wait state so hrdata comes from a flop
		if (s_q.pend_rd) begin
			s_d.pend_rd = 1'b0;
			s_d.ready   = 1'b1;
			s_d.rdata   = ssa_pkg::RDATA_RST;
			if (sel_acc) begin
				s_d.rdata = rd_acc_word;
			end else if (sel_flags) begin
				s_d.rdata = rd_flags_word;
			end else if (sel_cmd) begin
				s_d.rdata = s_q.cmd;
			end else if (sel_mem) begin
				s_d.rdata = rd_mem_word;
			end
		end

		// Address phase; hsize is not checked, only words are expected
		if (accept) begin
			s_d.addr    = haddr[7:0];
			s_d.pend_wr = hwrite;
			s_d.pend_rd = ~hwrite;
			if (!hwrite) begin
				s_d.ready = 1'b0;
			end
		end
	end

	// All state sits in one struct, so reset and update stay in step
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_q.ready           <= 1'b1;
			s_q.resp            <= ssa_pkg::HRESP_OKAY;
			s_q.rdata           <= ssa_pkg::RDATA_RST;
			s_q.pend_wr         <= 1'b0;
			s_q.pend_rd         <= 1'b0;
			s_q.addr            <= 8'h00;
			s_q.accumulator_reg <= ssa_pkg::ACC_RST;
			s_q.flags           <= ssa_pkg::FLAGS_RST;
			s_q.cmd             <= ssa_pkg::CMD_RST;
			s_q.mem             <= {MEM_DEPTH{ssa_pkg::MEM_RST}};
		end else begin
			s_q <= s_d;
		end
	end

	// Outputs come straight from the state flops
	assign hreadyout = s_q.ready;
	assign hresp     = s_q.resp;
	assign hrdata    = s_q.rdata;

endmodule : ssa_top

// ---- shared/ssa_pkg.sv ----
// Constants, offsets and types of the subtract/swap arithmetic slice.
// Assumes one AHB-Lite master and word-wide single transfers only.
package ssa_pkg;

	// Register byte offsets
	localparam logic [7:0]  OFF_ACC       = 8'h00;
	localparam logic [7:0]  OFF_FLAGS     = 8'h04;
	localparam logic [7:0]  OFF_CMD       = 8'h08;
	localparam logic [7:0]  OFF_MEM       = 8'h40;

	// Flag bit positions in the flags register
	localparam int          FLAG_C        = 0;
	localparam int          FLAG_AC       = 1;
	localparam int          FLAG_Z        = 2;
	localparam int          FLAG_OV       = 3;

	// Command word fields
	localparam int          CMD_OP_LSB    = 0;
	localparam int          CMD_ADDR_LSB  = 8;
	localparam int          CMD_IMM_LSB   = 16;

	// Values after reset
	localparam logic [7:0]  ACC_RST       = 8'h00;
	localparam logic [3:0]  FLAGS_RST     = 4'h0;
	localparam logic [31:0] CMD_RST       = 32'h00000000;
	localparam logic [7:0]  MEM_RST       = 8'h00;
	localparam logic [31:0] RDATA_RST     = 32'h00000000;

	// Bus encodings
	localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
	localparam logic        HRESP_OKAY    = 1'h0;

	typedef enum logic [1:0] {
		OP_SUB_MEM,
		OP_SUB_TO_MEM,
		OP_SUB_IMM,
		OP_SWAP
	} ssa_op_t;

endpackage : ssa_pkg

// ---- shared/ssa_alu_if.sv ----
// Operand and result bundle between the register core and the ALU.
// Assumes the ALU is purely combinational.
`timescale 1ns/1ns
interface ssa_alu_if;
	ssa_pkg::ssa_op_t op;
	logic [7:0]       accumulator_reg;
	logic [7:0]       operand;
	logic [7:0]       result;
	logic [3:0]       flags;
	logic             wr_acc;
	logic             wr_mem;
	logic             wr_flags;

	modport alu (
		input  op,
		input  accumulator_reg,
		input  operand,
		output result,
		output flags,
		output wr_acc,
		output wr_mem,
		output wr_flags
	);

	modport core (
		output op,
		output accumulator_reg,
		output operand,
		input  result,
		input  flags,
		input  wr_acc,
		input  wr_mem,
		input  wr_flags
	);
endinterface : ssa_alu_if

// ---- logic/ssa_alu.sv ----
// Combinational subtract and nibble-swap unit.
// Assumes the core picks the operand and applies the write enables.
`timescale 1ns/1ns
module ssa_alu (
	ssa_alu_if.alu u
);
	logic [8:0] diff;
	logic [4:0] half;

	always_comb begin
		diff       = {1'b0, u.accumulator_reg} - {1'b0, u.operand};
		half       = {1'b0, u.accumulator_reg[3:0]} - {1'b0, u.operand[3:0]};
		u.result   = diff[7:0];
		u.flags    = '0;
		u.wr_acc   = 1'b0;
		u.wr_mem   = 1'b0;
		u.wr_flags = 1'b1;
		u.flags[ssa_pkg::FLAG_C]  = ~diff[8];
		u.flags[ssa_pkg::FLAG_AC] = ~half[4];
		u.flags[ssa_pkg::FLAG_Z]  = (diff[7:0] == 8'h00);
		u.flags[ssa_pkg::FLAG_OV] = (u.accumulator_reg[7] ^ u.operand[7])
			& (u.accumulator_reg[7] ^ diff[7]);
		case (u.op)
			ssa_pkg::OP_SUB_MEM: begin
				u.wr_acc = 1'b1;
			end
			ssa_pkg::OP_SUB_TO_MEM: begin
				u.wr_mem = 1'b1;
			end
			ssa_pkg::OP_SUB_IMM: begin
				u.wr_acc = 1'b1;
			end
			ssa_pkg::OP_SWAP: begin
				u.result   = {u.operand[3:0], u.operand[7:4]};
				u.wr_mem   = 1'b1;
				u.wr_flags = 1'b0;
			end
			default: begin
				u.wr_flags = 1'b0;
			end
		endcase
	end
endmodule : ssa_alu

// ---- bench/ssa_top_properties.sv ----
// Bus timing and read-back width checks of the slice.
// Assumes hready is fed from hreadyout.
`timescale 1ns/1ns
module ssa_top_properties (
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [2:0]  hsize,
	input wire logic [31:0] hwdata,
	input wire logic        hready,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic [31:0] hrdata
);
	logic take;
	assign take = hsel && hready && htrans == ssa_pkg::HTRANS_NONSEQ;
	default clocking cb @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence one_wait;
		!hreadyout ##1 hreadyout;
	endsequence
	sequence rd_at(logic [7:0] off);
		take && !hwrite && haddr[7:0] == off;
	endsequence
	read_wait_a:
		assert property (take && !hwrite |=> one_wait)
		else $error("read wait state wrong");
	write_fast_a:
		assert property (take && hwrite |=> hreadyout)
		else $error("write inserted a wait");
	resp_okay_a:
		assert property (hresp == ssa_pkg::HRESP_OKAY)
		else $error("response not okay");
	acc_byte_a:
		assert property (rd_at(ssa_pkg::OFF_ACC) |=> ##1 hrdata[31:8] == 0)
		else $error("accumulator upper bits set");
	flag_bits_a:
		assert property (rd_at(ssa_pkg::OFF_FLAGS) |=> ##1 hrdata[31:4] == 0)
		else $error("flags upper bits set");
	mem_byte_a:
		assert property (rd_at(ssa_pkg::OFF_MEM) |=> ##1 hrdata[31:8] == 0)
		else $error("memory upper bits set");
endmodule : ssa_top_properties
bind ssa_top ssa_top_properties i_ssa_top_properties (.hclk(hclk),
	.hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
	.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));

// ---- bench/subtract_swap_alu_bench.sv ----
// Bench driving the slice over its register bus.
// Assumes hready is fed back from the one slave's hreadyout.
`timescale 1ns/1ns
module subtract_swap_alu_bench;
	logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
	logic [1:0]  htrans = 0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
	logic        hreadyout, hresp;
	int          n_fail = 0, samples_checked = 0;
	always #10 hclk = ~hclk;
	ssa_top i_ssa_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata));
	// Wait on hready in both phases; the read has a wait state
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		hsel <= 1;
		htrans <= ssa_pkg::HTRANS_NONSEQ;
		hwrite <= w;
		haddr <= {24'h0, a};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : xfer
	task automatic cmp(input string n, input logic [31:0] e, g);
		samples_checked++;
		if (g !== e) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask : cmp
	task automatic chk(input string n, input logic [7:0] a,
		input logic [31:0] e);
		xfer(0, a, 32'h0);
		cmp(n, e, rd);
	endtask : chk
	// Flags preset to 9 so the swap shows it leaves them alone
	task automatic run_op(input logic [1:0] op, input logic [7:0] a, m, x);
		logic [7:0] s, d;
		logic [3:0] f;
		logic [31:0] c;
		s = (op == 2'h2) ? x : m;
		c = {8'h00, x, 8'h00, 6'h00, op};
		d = a - s;
		f = {(a[7] != s[7]) && (d[7] != a[7]), d == 8'h0,
			a[3:0] >= s[3:0], a >= s};
		xfer(1'b1, ssa_pkg::OFF_ACC, {24'h0, a});
		xfer(1'b1, ssa_pkg::OFF_FLAGS, 32'h9);
		xfer(1'b1, ssa_pkg::OFF_MEM, {24'h0, m});
		xfer(1'b1, ssa_pkg::OFF_CMD, c);
		if (op == 2'h3) begin
			f = 4'h9;
			d = a;
			m = {m[3:0], m[7:4]};
		end else if (op == 2'h1) begin
			m = d;
			d = a;
		end
		chk("acc", ssa_pkg::OFF_ACC, {24'h0, d});
		chk("flags", ssa_pkg::OFF_FLAGS, {28'h0, f});
		chk("mem", ssa_pkg::OFF_MEM, {24'h0, m});
		chk("cmd", ssa_pkg::OFF_CMD, c);
		$display("test op %0d done", op);
	endtask : run_op
	task automatic complete_run();
		$display("checks %0d failures %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : complete_run
	initial begin
		repeat (2000) @(posedge hclk);
		n_fail++;
		complete_run();
	end
	initial begin
		repeat (6) @(posedge hclk);
		hresetn <= 1;
		@(posedge hclk);
		chk("acc", ssa_pkg::OFF_ACC, 32'h0);
		chk("flags", ssa_pkg::OFF_FLAGS, 32'h0);
		chk("gap", 8'h0C, 32'h0);
		$display("test reset done");
		run_op(2'h0, 8'h50, 8'h30, 8'h00);
		run_op(2'h0, 8'h30, 8'h50, 8'h00);
		run_op(2'h1, 8'h80, 8'h01, 8'h00);
		run_op(2'h1, 8'h10, 8'h11, 8'h00);
		run_op(2'h2, 8'h05, 8'hFF, 8'h05);
		run_op(2'h2, 8'h10, 8'h33, 8'h01);
		run_op(2'h3, 8'h7E, 8'hA5, 8'h00);
		complete_run();
	end
endmodule : subtract_swap_alu_bench
